//--- rtl/lics_pkg.sv
// Constants and types shared by the alarm change latch and cable loss block.
`default_nettype none
package lics_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned FLAG_W = 7;
    localparam int unsigned LEVEL_W = 6;
    localparam int unsigned CLOSS_W = 6;
    localparam int unsigned PTR_W = 6;

    // Register indices; the byte address of each is four times its index.
    localparam logic [ADDR_W-1:0] IDX_ALARM_CHANGE_LATCH = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_CABLE_LOSS_ESTIMATE = 8'h07;
    localparam logic [ADDR_W-1:0] IDX_ALARM_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_STATUS_LEVEL = 8'h11;
    localparam int unsigned IDX_SHIFT = 2;

    // Bit positions inside the alarm change latch and the enable register.
    localparam int unsigned BIT_PRBS_SYNC = 0;
    localparam int unsigned BIT_SIGNAL_LOSS = 1;
    localparam int unsigned BIT_ALL_ONES = 2;
    localparam int unsigned BIT_LOOP_CODE = 3;
    localparam int unsigned BIT_CODE_VIOL = 4;
    localparam int unsigned BIT_FIFO_LIMIT = 5;
    localparam int unsigned BIT_DRIVER_MON = 6;

    // Bit positions of the six synchronised status levels.
    localparam int unsigned LVL_PRBS_SYNC = 0;
    localparam int unsigned LVL_SIGNAL_LOSS = 1;
    localparam int unsigned LVL_ALL_ONES = 2;
    localparam int unsigned LVL_LOOP_CODE = 3;
    localparam int unsigned LVL_CODE_VIOL = 4;
    localparam int unsigned LVL_DRIVER_MON = 5;

    localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
    localparam logic [FLAG_W-1:0] ENABLE_RESET = 7'h00;
    localparam logic [CLOSS_W-1:0] CLOSS_RESET = 6'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 6'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // Jitter FIFO limit: pointers within this many positions of each other.
    localparam logic [PTR_W-1:0] FIFO_LIMIT_GAP = 6'h03;
    localparam logic [PTR_W-1:0] FIFO_MASK_32 = 6'h1f;
    localparam logic [PTR_W-1:0] FIFO_MASK_64 = 6'h3f;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic {
        LICS_WR_IDLE = 1'b0,
        LICS_WR_RESP = 1'b1
    } lics_wr_state_e;

    typedef enum logic {
        LICS_RD_IDLE = 1'b0,
        LICS_RD_RESP = 1'b1
    } lics_rd_state_e;

    function automatic logic [ADDR_W-1:0] lics_byte_addr(input logic [ADDR_W-1:0] idx);
        lics_byte_addr = ADDR_W'(idx << IDX_SHIFT);
    endfunction : lics_byte_addr
endpackage : lics_pkg
`default_nettype wire

//--- rtl/lics_sync.sv
// Two flip-flop synchroniser for a group of independent status levels.
`default_nettype none
module lics_sync
    import lics_pkg::*;
#(
    parameter int unsigned WIDTH = LEVEL_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Each bit is a separate level, so bitwise synchronising is safe here.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : lics_sync
`default_nettype wire

//--- rtl/lics_fifo_limit.sv
// Jitter FIFO limit detector: flags pointers that come close to each other.
`default_nettype none
module lics_fifo_limit
    import lics_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PTR_W-1:0] wr_ptr,
    input wire logic [PTR_W-1:0] rd_ptr,
    input wire logic depth_64,
    output logic near_limit
);
    logic [PTR_W-1:0] mask;
    logic [PTR_W-1:0] gap;
    logic near_d;
    logic near_q;

    assign mask = depth_64 ? FIFO_MASK_64 : FIFO_MASK_32;
    assign gap = (wr_ptr - rd_ptr) & mask;
    // Close in either direction: a gap of 0..3 or of depth-3..depth-1.
    assign near_d = (gap <= FIFO_LIMIT_GAP) || (gap >= ((mask - FIFO_LIMIT_GAP) + 6'h01));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            near_q <= 1'b0;
        end else begin
            near_q <= near_d;
        end
    end

    assign near_limit = near_q;
endmodule : lics_fifo_limit
`default_nettype wire

//--- rtl/lics_top.sv
// Alarm change latch, interrupt gating and cable loss readback behind AXI4-Lite.
//
// Behaviour
// - Driver monitor level change since last read sets latch bit 6.
// - FIFO limit is pointers within 3; its change sets latch bit 5.
// - Line code violation status change sets latch bit 4.
// - Network loop-code detect status change sets latch bit 3.
// - All-ones alarm detect status change sets latch bit 2.
// - Receive loss-of-signal status change sets latch bit 1.
// - PRBS synchronisation status change sets latch bit 0.
// - Cable loss register bits 5..0 show the selected equalizer setting.
// - Cable loss is an unsigned binary attenuation estimate in about 1 dB steps.
// - Cable loss MSB sits at bit 5 and LSB at bit 0.
// - A change raises the interrupt only when its enable bit is set.
//
// Register access over AXI4-Lite is this design's own decision.
`default_nettype none
module lics_top
    import lics_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic driver_monitor_status,
    input wire logic code_violation_status,
    input wire logic loop_code_detect_status,
    input wire logic all_ones_alarm_status,
    input wire logic receive_signal_loss_status,
    input wire logic prbs_sync_status,
    input wire logic [PTR_W-1:0] jitter_fifo_wr_ptr,
    input wire logic [PTR_W-1:0] jitter_fifo_rd_ptr,
    input wire logic jitter_fifo_depth_64,
    input wire logic [CLOSS_W-1:0] cable_loss_value,
    output logic irq
);
    // Address decode against one register's index, word aligned.
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] idx);
        logic [ADDR_W-1:0] base;
        base = lics_byte_addr(idx);
        // The low two bits pick a byte lane only.
        reg_hit = (addr[ADDR_W-1:IDX_SHIFT] == base[ADDR_W-1:IDX_SHIFT]);
    endfunction : reg_hit

    // Other words answer DECERR and have no effect.
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = reg_hit(addr, IDX_ALARM_CHANGE_LATCH)
                  || reg_hit(addr, IDX_CABLE_LOSS_ESTIMATE)
                  || reg_hit(addr, IDX_ALARM_ENABLE)
                  || reg_hit(addr, IDX_STATUS_LEVEL);
    endfunction : reg_mapped

    // Status levels from the line side.
    // They are asynchronous; each bit is its own
    // level, so per-bit synchronising is safe.
    logic [LEVEL_W-1:0] level_raw;
    logic [LEVEL_W-1:0] level_sync;
    logic fifo_near;

    assign level_raw[LVL_PRBS_SYNC] = prbs_sync_status;
    assign level_raw[LVL_SIGNAL_LOSS] = receive_signal_loss_status;
    assign level_raw[LVL_ALL_ONES] = all_ones_alarm_status;
    assign level_raw[LVL_LOOP_CODE] = loop_code_detect_status;
    assign level_raw[LVL_CODE_VIOL] = code_violation_status;
    assign level_raw[LVL_DRIVER_MON] = driver_monitor_status;

    lics_sync #(
        .WIDTH(LEVEL_W)
    ) u_level_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(level_raw),
        .sync_out(level_sync)
    );

    // Pointers share aclk and need no synchroniser;
    // the test is registered to shorten the path.
    lics_fifo_limit u_fifo_limit (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_ptr(jitter_fifo_wr_ptr),
        .rd_ptr(jitter_fifo_rd_ptr),
        .depth_64(jitter_fifo_depth_64),
        .near_limit(fifo_near)
    );

    // Current condition vector in latch layout.
    // The FIFO flag is one flop deep, the levels
    // two, so its changes land a cycle sooner.
    logic [FLAG_W-1:0] cond_now;
    logic [FLAG_W-1:0] cond_prev_q;
    logic [FLAG_W-1:0] change;

    assign cond_now[BIT_DRIVER_MON] = level_sync[LVL_DRIVER_MON];
    assign cond_now[BIT_FIFO_LIMIT] = fifo_near;
    assign cond_now[BIT_CODE_VIOL] = level_sync[LVL_CODE_VIOL];
    assign cond_now[BIT_LOOP_CODE] = level_sync[LVL_LOOP_CODE];
    assign cond_now[BIT_ALL_ONES] = level_sync[LVL_ALL_ONES];
    assign cond_now[BIT_SIGNAL_LOSS] = level_sync[LVL_SIGNAL_LOSS];
    assign cond_now[BIT_PRBS_SYNC] = level_sync[LVL_PRBS_SYNC];

    // The reset value of the previous vector is all low, so a condition that
    // is already active when reset is released is reported as a change.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_prev_q <= FLAGS_RESET;
        end else begin
            cond_prev_q <= cond_now;
        end
    end

    // Any transition, rising or falling, counts as a change.
    // A condition that toggles twice between two
    // reads still leaves its latch bit set.
    assign change[BIT_DRIVER_MON] = cond_now[BIT_DRIVER_MON] ^ cond_prev_q[BIT_DRIVER_MON];
    assign change[BIT_FIFO_LIMIT] = cond_now[BIT_FIFO_LIMIT] ^ cond_prev_q[BIT_FIFO_LIMIT];
    assign change[BIT_CODE_VIOL] = cond_now[BIT_CODE_VIOL] ^ cond_prev_q[BIT_CODE_VIOL];
    assign change[BIT_LOOP_CODE] = cond_now[BIT_LOOP_CODE] ^ cond_prev_q[BIT_LOOP_CODE];
    assign change[BIT_ALL_ONES] = cond_now[BIT_ALL_ONES] ^ cond_prev_q[BIT_ALL_ONES];
    assign change[BIT_SIGNAL_LOSS] = cond_now[BIT_SIGNAL_LOSS] ^ cond_prev_q[BIT_SIGNAL_LOSS];
    assign change[BIT_PRBS_SYNC] = cond_now[BIT_PRBS_SYNC] ^ cond_prev_q[BIT_PRBS_SYNC];

    // Cable loss estimate from the receive equalizer, same clock domain.
    // The value read is one cycle old, a cheap
    // price for a short read mux.
    logic [CLOSS_W-1:0] cable_loss_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cable_loss_q <= CLOSS_RESET;
        end else begin
            cable_loss_q <= cable_loss_value;
        end
    end

    // Write channel.
    // Ready is combinational; address and data may
    // come in either order and are held until both
    // are present. The write commits a cycle later.
    // One write at a time keeps the holding simple.
    lics_wr_state_e wr_state_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q;
    logic wr_go;

    assign s_axi_awready = (wr_state_q == LICS_WR_IDLE) && !aw_held_q;
    assign s_axi_wready = (wr_state_q == LICS_WR_IDLE) && !w_held_q;
    assign wr_go = (wr_state_q == LICS_WR_IDLE) && aw_held_q && w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= LICS_WR_IDLE;
            bresp_q <= RESP_OKAY;
        end else begin
            unique case (wr_state_q)
                LICS_WR_IDLE: begin
                    if (wr_go) begin
                        wr_state_q <= LICS_WR_RESP;
                        bresp_q <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
                    end
                end
                // No new request is taken until bready.
                LICS_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= LICS_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // The response flag is the state, glitch free.
    assign s_axi_bvalid = (wr_state_q == LICS_WR_RESP);
    assign s_axi_bresp = bresp_q;

    // Writes touch only byte lane 0; the registers are eight bits wide.
    // A write with lane 0 off to a mapped word answers OKAY only.
    logic wr_lane0;
    logic wr_enable_reg;
    logic wr_latch_reg;

    assign wr_lane0 = wr_go && wstrb0_q;
    assign wr_enable_reg = wr_lane0 && reg_hit(awaddr_q, IDX_ALARM_ENABLE);
    assign wr_latch_reg = wr_lane0 && reg_hit(awaddr_q, IDX_ALARM_CHANGE_LATCH);

    // Enable bits line up with the latch bits.
    logic [FLAG_W-1:0] enable_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_enable_reg) begin
            enable_q <= wdata_q[FLAG_W-1:0];
        end
    end

    // Read channel.
    // The word is captured at the address edge, so
    // a latch read returns what that edge clears.
    // One read at a time: arready waits for rready.
    lics_rd_state_e rd_state_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_take;
    logic rd_latch_reg;
    logic [DATA_W-1:0] rd_word;

    assign s_axi_arready = (rd_state_q == LICS_RD_IDLE);
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_latch_reg = rd_take && reg_hit(s_axi_araddr, IDX_ALARM_CHANGE_LATCH);

    logic [FLAG_W-1:0] latch_q;
    logic [FLAG_W-1:0] latch_d;

    // Reserved bits above each field are zero-extended into the data word.
    always_comb begin
        rd_word = RDATA_RESET;
        if (reg_hit(s_axi_araddr, IDX_ALARM_CHANGE_LATCH)) begin
            rd_word = DATA_W'(latch_q);
        end else if (reg_hit(s_axi_araddr, IDX_CABLE_LOSS_ESTIMATE)) begin
            rd_word = DATA_W'(cable_loss_q);
        end else if (reg_hit(s_axi_araddr, IDX_ALARM_ENABLE)) begin
            rd_word = DATA_W'(enable_q);
        end else if (reg_hit(s_axi_araddr, IDX_STATUS_LEVEL)) begin
            // Conditions as the change detector sees them.
            rd_word = DATA_W'(cond_now);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= LICS_RD_IDLE;
            rdata_q <= RDATA_RESET;
            rresp_q <= RESP_OKAY;
        end else begin
            unique case (rd_state_q)
                LICS_RD_IDLE: begin
                    if (rd_take) begin
                        rd_state_q <= LICS_RD_RESP;
                        rdata_q <= rd_word;
                        rresp_q <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
                    end
                end
                // The answer stands until rready.
                LICS_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_q <= LICS_RD_IDLE;
                    end
                end
            endcase
        end
    end

    // Valid is the state itself, so it cannot glitch.
    assign s_axi_rvalid = (rd_state_q == LICS_RD_RESP);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // The latch is cleared by the read that samples it, and bits written as one
    // are cleared too; a change arriving in that very cycle is set afterwards,
    // so it is neither lost nor reported twice.
    // Write-one-to-clear serves hosts that prefer it.
    always_comb begin
        latch_d = latch_q;
        if (rd_latch_reg) begin
            latch_d = FLAGS_RESET;
        end else if (wr_latch_reg) begin
            latch_d = latch_q & ~wdata_q[FLAG_W-1:0];
        end
        latch_d = latch_d | change;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= FLAGS_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Latch bits record every change; only enabled ones reach the pin.
    // The pin is registered to keep it glitch free;
    // the next latch value wins back a cycle on a clear.
    logic irq_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(latch_d & enable_q);
        end
    end

    assign irq = irq_q;
endmodule : lics_top
`default_nettype wire

//--- tb/lics_asserts.sv
// Checker for bus answers, reserved bits and interrupt timing of the alarm latch block.
`default_nettype none
module lics_asserts
    import lics_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CLOSS_W-1:0] cable_loss_value,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic ar_hs;
    logic ar_bad;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    // Only the four mapped words may answer with OKAY.
    assign ar_bad = !(s_axi_araddr[7:2] inside {6'h06, 6'h07, 6'h10, 6'h11});
    a_read_answer: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer not held");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
        else $error("reserved read bits not zero");
    a_unmapped_read: assert property (ar_hs && ar_bad |=>
        s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_closs_read: assert property (ar_hs && s_axi_araddr == 8'h1c
        && $stable(cable_loss_value) |=> s_axi_rdata == {26'h0, $past(cable_loss_value)})
        else $error("cable loss read mismatch");
    a_irq_fall: assert property ($fell(irq) |-> $past(ar_hs) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without a host access");
    c_unmapped: cover property (ar_hs && ar_bad);
    c_irq_rise: cover property ($rose(irq));
    c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
endmodule : lics_asserts
bind lics_top lics_asserts u_lics_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cable_loss_value(cable_loss_value), .irq(irq)
);
`default_nettype wire

//--- tb/lics_host.sv
// Host model that reaches the block's registers over AXI4-Lite.
`default_nettype none
module lics_host
    import lics_pkg::*;
(
    input wire logic aclk,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [DATA_W-1:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Each channel is released only at the edge where it was taken.
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            aw_done = aw_done || awready;
            w_done = w_done || wready;
            awvalid <= !aw_done;
            wvalid <= !w_done;
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : lics_host
`default_nettype wire

//--- tb/lics_top_tb.sv
// Self-checking testbench for the alarm change latch and cable loss block.
`default_nettype none
module lics_top_tb
    import lics_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [5:0] lvl = 6'h00;
    // Pointers start far apart so the limit does not fire out of reset.
    logic [PTR_W-1:0] wr_ptr = 6'h10;
    logic [PTR_W-1:0] rd_ptr = 6'h00;
    logic depth_64 = 1'b0;
    logic [CLOSS_W-1:0] closs = 6'h00;
    logic irq;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int lbit[6] = '{BIT_PRBS_SYNC, BIT_SIGNAL_LOSS, BIT_ALL_ONES, BIT_LOOP_CODE,
        BIT_CODE_VIOL, BIT_DRIVER_MON};
    always #12.5 aclk = ~aclk;
    lics_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    lics_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .driver_monitor_status(lvl[LVL_DRIVER_MON]),
        .code_violation_status(lvl[LVL_CODE_VIOL]), .loop_code_detect_status(lvl[LVL_LOOP_CODE]),
        .all_ones_alarm_status(lvl[LVL_ALL_ONES]),
        .receive_signal_loss_status(lvl[LVL_SIGNAL_LOSS]), .prbs_sync_status(lvl[LVL_PRBS_SYNC]),
        .jitter_fifo_wr_ptr(wr_ptr), .jitter_fifo_rd_ptr(rd_ptr),
        .jitter_fifo_depth_64(depth_64), .cable_loss_value(closs), .irq(irq));
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd_expect(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk("read data", exp, d);
        chk("read response", {30'h0, er}, {30'h0, r});
    endtask : rd_expect
    task automatic wr_expect(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, r);
        chk("write response", {30'h0, er}, {30'h0, r});
    endtask : wr_expect
    task automatic t_reset_values();
        rd_expect(8'h18, 32'h0, RESP_OKAY);
        rd_expect(8'h1c, 32'h0, RESP_OKAY);
        rd_expect(8'h40, 32'h0, RESP_OKAY);
    endtask : t_reset_values
    task automatic t_flags();
        for (int i = 0; i < 6; i++) begin
            lvl[i] <= 1'b1;
            repeat (5) @(posedge aclk);
            rd_expect(8'h18, 32'h1 << lbit[i], RESP_OKAY);
            rd_expect(8'h18, 32'h0, RESP_OKAY);
            lvl[i] <= 1'b0;
            repeat (5) @(posedge aclk);
            rd_expect(8'h18, 32'h1 << lbit[i], RESP_OKAY);
        end
    endtask : t_flags
    task automatic t_fifo_limit();
        logic [PTR_W-1:0] wp[5] = '{6'h03, 6'h04, 6'h05, 6'h1e, 6'h1e};
        logic [4:0] hit = 5'b11011;
        for (int i = 0; i < 5; i++) begin
            wr_ptr <= wp[i];
            depth_64 <= (i == 4);
            repeat (4) @(posedge aclk);
            rd_expect(8'h18, {26'h0, hit[i], 5'h0}, RESP_OKAY);
        end
    endtask : t_fifo_limit
    task automatic t_cable_loss();
        logic [CLOSS_W-1:0] v[3] = '{6'h2b, 6'h3f, 6'h01};
        for (int i = 0; i < 3; i++) begin
            closs <= v[i];
            repeat (3) @(posedge aclk);
            rd_expect(8'h1c, {26'h0, v[i]}, RESP_OKAY);
        end
        wr_expect(8'h1c, 32'hff, RESP_OKAY);
        rd_expect(8'h1c, 32'h01, RESP_OKAY);
    endtask : t_cable_loss
    task automatic t_irq_mask();
        wr_expect(8'h40, 32'h1 << BIT_SIGNAL_LOSS, RESP_OKAY);
        lvl[LVL_CODE_VIOL] <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        lvl[LVL_SIGNAL_LOSS] <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr_expect(8'h18, 32'h7f, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd_expect(8'h44, 32'h12, RESP_OKAY);
        lvl[LVL_SIGNAL_LOSS] <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq});
        rd_expect(8'h18, 32'h1 << BIT_SIGNAL_LOSS, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, {31'h0, irq});
    endtask : t_irq_mask
    task automatic t_bad_address();
        rd_expect(8'h30, 32'h0, RESP_DECERR);
        wr_expect(8'h30, 32'h7f, RESP_DECERR);
    endtask : t_bad_address
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_flags();
        t_fifo_limit();
        t_cable_loss();
        t_irq_mask();
        t_bad_address();
        summarize();
    end
endmodule : lics_top_tb
`default_nettype wire
